// file: spi_port.sv
// byte-wide serial port core, master or slave, cpu clock domain
// assumes the cpu drives the access strobes as one-cycle pulses on clk
// and that sck_link is the serial clock pin as seen by a slave
//
// What this block does
// - master drives sck at software-chosen rate, idle level and phase
// - in master mode, master and enable bits hold only while internal select is high
// - master data write loads shift register, sends msb first on mosi
// - each byte end sets done flag; interrupt when enabled and unmasked
// - done flag clears after status access then data read or write
// - data writes ignored while done flag set until status read
// - slave clocks from external sck, shifts preloaded byte on miso
// - idle level and phase pick one of four capture relations
// - select low in master mode: fault flag, drop enable and master
// - fault flag clears on status read then control write
// - while fault set, enable and master cannot be set except clearing
// - byte end with done flag set: overrun, buffer keeps first byte
// - overrun flag clears on status read
// - data write mid-transfer discarded, collision flag, no interrupt
// - received byte copied to cpu buffer; data reads return buffer
// - wait: runs and wakes; halt: control registers frozen, bytes still received, overrun possible
// - only done event wakes from halt, if selected at halt entry
// - phase zero captures on first edge, phase one on second
// - idle level zero idles sck low, one idles it high
`timescale 1ns/1ps
`include "spi_port_params.svh"

module spi_port (
  // clocks and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck_link,
  // control register access
  input wire logic cr_wr,
  input wire spi_port_pkg::cfg_t cr_wdata,
  // control-status register access
  input wire logic csr_rd,
  input wire logic csr_wr,
  input wire spi_port_pkg::csr_ctl_t csr_wdata,
  // data register access
  input wire logic dr_wr,
  input wire logic [`BYTE_W-1:0] dr_wdata,
  input wire logic dr_rd,
  // cpu state
  input wire logic cpu_irq_mask,
  input wire logic halt,
  // register contents
  output spi_port_pkg::cfg_t cfg,
  output spi_port_pkg::csr_ctl_t csr_ctl,
  output spi_port_pkg::status_t status,
  output logic [`BYTE_W-1:0] dr_rdata,
  output logic irq,
  output logic wake,
  // serial pins
  input wire logic ss_pin_n,
  input wire logic mosi_in,
  input wire logic miso_in,
  output logic sck_o,
  output logic sck_oe,
  output logic mosi_o,
  output logic mosi_oe,
  output logic miso_o,
  output logic miso_oe
);
  import spi_port_pkg::*;

  function automatic logic [`DIV_CNT_W-1:0] half_period(
    input logic [2:0] rate
  );
    case (rate)
      `RATE_DIV4: half_period = `HALF_DIV4;
      `RATE_DIV8: half_period = `HALF_DIV8;
      `RATE_DIV16: half_period = `HALF_DIV16;
      `RATE_DIV32: half_period = `HALF_DIV32;
      `RATE_DIV64: half_period = `HALF_DIV64;
      `RATE_DIV128: half_period = `HALF_DIV128;
      default: half_period = `HALF_DIV8;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin and link-domain crossings
  logic [`BYTE_W-1:0] link_rx, tx_byte;
  logic link_start, link_done, link_miso, link_rstn;
  logic [`SYNC_W-1:0] s1, s2, s3, clean, next_clean, raw;

  assign raw = {link_done, link_start, miso_in, ss_pin_n};

  // a lane moves only once stages two and three agree
  always_comb begin
    for (int i = 0; i < `SYNC_W; i++) begin
      next_clean[i] = (s2[i] == s3[i]) ? s3[i] : clean[i];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= `SYNC_RST;
      s2 <= `SYNC_RST;
      s3 <= `SYNC_RST;
      clean <= `SYNC_RST;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      clean <= next_clean;
    end
  end

  // lanes reset to their source's idle level, so no false toggle follows
  logic tgl_seen, next_tgl_seen;
  logic s_start, s_done;
  assign next_tgl_seen = 1'b1;
  assign s_start = tgl_seen &
    (next_clean[`LANE_START] != clean[`LANE_START]);
  assign s_done = tgl_seen & (next_clean[`LANE_DONE] != clean[`LANE_DONE]);

  slave_link u_link (
    .sck(sck_link),
    .rstn(rstn),
    .link_rstn(link_rstn),
    .idle_level_bit(cfg.idle_level_bit),
    .capture_phase_bit(cfg.capture_phase_bit),
    .mosi(mosi_in),
    .miso(link_miso),
    .tx_byte(tx_byte),
    .rx_byte(link_rx),
    .start_tgl(link_start),
    .done_tgl(link_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // master engine and register state
  m_state_t m_state, next_m_state;
  logic [`DIV_CNT_W-1:0] div_cnt, next_div_cnt;
  logic [`EDGE_CNT_W-1:0] edge_k, next_edge_k;
  logic [`BYTE_W-1:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh;
  logic [`BYTE_W-1:0] next_tx_byte, next_dr_rdata;
  logic next_sck_o, next_link_rstn;
  cfg_t next_cfg;
  csr_ctl_t next_csr_ctl;
  status_t next_status;
  logic done_armed, next_done_armed, done_read, next_done_read;
  logic write_collision_flag_armed, next_write_collision_flag_armed, mf_armed, next_mf_armed;
  logic s_busy, next_s_busy, halt_q, halt_sel, next_halt_sel;
  logic next_irq, next_wake, next_sck_oe, next_mosi_oe, next_miso_oe;
  logic run, ss_low, fault, busy, inhibit, accept, m_done, done_ev;
  logic done_clr, tdf_eff, slave_en;
  logic [`BYTE_W-1:0] done_byte;

  always_comb begin
    run = ~halt;
    ss_low = csr_ctl.select_source_bit ? ~csr_ctl.soft_select_bit
                                       : ~clean[`LANE_SS];
    fault = cfg.master_select_bit & ss_low;
    slave_en = cfg.port_enable_bit & ~cfg.master_select_bit;
    busy = (m_state == M_RUN) | s_busy |
      (slave_en & ~cfg.capture_phase_bit & ss_low);
    inhibit = status.transfer_done_flag & ~done_read;
    accept = run & dr_wr & ~inhibit & ~busy;

    // master shifter
    next_m_state = m_state;
    next_div_cnt = div_cnt;
    next_edge_k = edge_k;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_sck_o = sck_o;
    m_done = 1'b0;
    if (run) begin
      case (m_state)
        M_IDLE: begin
          next_sck_o = cfg.idle_level_bit;
          if (accept & cfg.master_select_bit & cfg.port_enable_bit) begin
            next_tx_sh = dr_wdata;
            next_div_cnt = 6'h00;
            next_edge_k = 4'h0;
            next_m_state = M_RUN;
          end
        end
        M_RUN: begin
          if (div_cnt == half_period(cfg.rate_select_field)) begin
            next_div_cnt = 6'h00;
            next_sck_o = ~sck_o;
            next_edge_k = edge_k + 4'h1;
            if (edge_k[0] == cfg.capture_phase_bit) begin
              next_rx_sh = {rx_sh[`BYTE_W-2:0], clean[`LANE_MISO]};
            end else if (!(cfg.capture_phase_bit && edge_k == 4'h0)) begin
              next_tx_sh = {tx_sh[`BYTE_W-2:0], 1'b0};
            end
            if (edge_k == `LAST_EDGE) begin
              m_done = 1'b1;
              next_m_state = M_IDLE;
            end
          end else begin
            next_div_cnt = div_cnt + 6'h01;
          end
        end
        default: next_m_state = M_IDLE;
      endcase
      if (fault | ~cfg.port_enable_bit) begin
        next_m_state = M_IDLE;
        next_sck_o = cfg.idle_level_bit;
        m_done = 1'b0;
      end
    end

    // slave progress is tracked even in halt so a byte can wake the cpu
    next_s_busy = s_busy;
    if (s_start) begin
      next_s_busy = 1'b1;
    end
    if (s_done | ~slave_en) begin
      next_s_busy = 1'b0;
    end

    done_ev = m_done | s_done;
    done_byte = m_done ? next_rx_sh : link_rx;

    // done flag: status access arms, data access clears, set wins
    done_clr = run & done_armed & (dr_rd | dr_wr);
    tdf_eff = status.transfer_done_flag & ~done_clr;
    next_status = status;
    next_status.transfer_done_flag = tdf_eff | done_ev;
    next_done_armed = done_armed;
    next_done_read = done_read;
    if (run & (csr_rd | csr_wr) & status.transfer_done_flag) begin
      next_done_armed = 1'b1;
    end
    if (run & csr_rd & status.transfer_done_flag) begin
      next_done_read = 1'b1;
    end
    if (~next_status.transfer_done_flag) begin
      next_done_armed = 1'b0;
      next_done_read = 1'b0;
    end

    // receive buffer keeps the first byte after the last clear
    next_dr_rdata = dr_rdata;
    if (done_ev & ~tdf_eff) begin
      next_dr_rdata = done_byte;
    end
    next_status.overrun_flag = (status.overrun_flag & ~(run & csr_rd)) |
      (done_ev & tdf_eff);

    // write collision: status only, cleared by status read then data access
    next_write_collision_flag_armed = write_collision_flag_armed;
    if (run & csr_rd & status.write_collision_flag) begin
      next_write_collision_flag_armed = 1'b1;
    end
    next_status.write_collision_flag = status.write_collision_flag;
    if (write_collision_flag_armed & run & (dr_rd | dr_wr)) begin
      next_status.write_collision_flag = 1'b0;
      next_write_collision_flag_armed = 1'b0;
    end
    if (run & dr_wr & ~inhibit & busy) begin
      next_status.write_collision_flag = 1'b1;
    end

    next_tx_byte = tx_byte;
    if (accept) begin
      next_tx_byte = dr_wdata;
    end

    // control registers and master fault
    next_cfg = cfg;
    next_csr_ctl = csr_ctl;
    next_mf_armed = mf_armed;
    next_status.master_fault_flag = status.master_fault_flag;
    if (run & csr_rd & status.master_fault_flag) begin
      next_mf_armed = 1'b1;
    end
    if (run & csr_wr) begin
      next_csr_ctl = csr_wdata;
    end
    if (run & cr_wr) begin
      next_cfg = cr_wdata;
      if (status.master_fault_flag & ~mf_armed) begin
        next_cfg.port_enable_bit = cr_wdata.port_enable_bit &
          cfg.port_enable_bit;
        next_cfg.master_select_bit = cr_wdata.master_select_bit &
          cfg.master_select_bit;
      end
      if (mf_armed) begin
        next_status.master_fault_flag = 1'b0;
        next_mf_armed = 1'b0;
      end
    end
    if (run & fault) begin
      next_status.master_fault_flag = 1'b1;
      next_cfg.port_enable_bit = 1'b0;
      next_cfg.master_select_bit = 1'b0;
    end

    // interrupt and halt wake-up
    next_irq = cfg.irq_enable_bit & ~cpu_irq_mask &
      (status.transfer_done_flag | status.overrun_flag |
       status.master_fault_flag);
    next_halt_sel = halt_sel;
    if (halt & ~halt_q) begin
      next_halt_sel = ss_low;
    end
    next_wake = halt & halt_sel & s_done;

    // pin enables; slave output only while this slave is selected
    next_sck_oe = next_cfg.port_enable_bit & next_cfg.master_select_bit;
    next_mosi_oe = next_sck_oe & ~next_csr_ctl.output_disable_bit;
    next_link_rstn = next_cfg.port_enable_bit &
      ~next_cfg.master_select_bit & ss_low;
    next_miso_oe = next_link_rstn & ~next_csr_ctl.output_disable_bit;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      m_state <= M_IDLE;
      div_cnt <= 6'h00;
      edge_k <= 4'h0;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      tx_byte <= 8'h00;
      dr_rdata <= 8'h00;
      sck_o <= 1'b0;
      cfg <= '0;
      csr_ctl <= '0;
      status <= '0;
      done_armed <= 1'b0;
      done_read <= 1'b0;
      write_collision_flag_armed <= 1'b0;
      mf_armed <= 1'b0;
      s_busy <= 1'b0;
      tgl_seen <= 1'b0;
      halt_q <= 1'b0;
      halt_sel <= 1'b0;
      irq <= 1'b0;
      wake <= 1'b0;
      sck_oe <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
      link_rstn <= 1'b0;
    end else begin
      m_state <= next_m_state;
      div_cnt <= next_div_cnt;
      edge_k <= next_edge_k;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      tx_byte <= next_tx_byte;
      dr_rdata <= next_dr_rdata;
      sck_o <= next_sck_o;
      cfg <= next_cfg;
      csr_ctl <= next_csr_ctl;
      status <= next_status;
      done_armed <= next_done_armed;
      done_read <= next_done_read;
      write_collision_flag_armed <= next_write_collision_flag_armed;
      mf_armed <= next_mf_armed;
      s_busy <= next_s_busy;
      tgl_seen <= next_tgl_seen;
      halt_q <= halt;
      halt_sel <= next_halt_sel;
      irq <= next_irq;
      wake <= next_wake;
      sck_oe <= next_sck_oe;
      mosi_oe <= next_mosi_oe;
      miso_oe <= next_miso_oe;
      link_rstn <= next_link_rstn;
    end
  end

  // mosi is the shifter msb; miso must follow the link clock directly,
  // a clk flop here would cost a whole bit at the top slave rate
  assign mosi_o = tx_sh[`BYTE_W-1];
  assign miso_o = link_miso;

endmodule

// file: spi_port_params.svh
// constants for the byte-wide serial port: widths, rate codes, counts
// assumes inclusion by bare name from every file that needs a figure
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

`define BYTE_W 8
`define BIT_CNT_W 3
`define LAST_BIT 3'h7
`define EDGE_CNT_W 4
`define LAST_EDGE 4'hf
`define DIV_CNT_W 6

// rate_select_field codes
`define RATE_DIV4 3'h4
`define RATE_DIV8 3'h0
`define RATE_DIV16 3'h1
`define RATE_DIV32 3'h6
`define RATE_DIV64 3'h2
`define RATE_DIV128 3'h3

// half sck period minus one, in clk cycles, per divider
`define HALF_DIV4 6'h01
`define HALF_DIV8 6'h03
`define HALF_DIV16 6'h07
`define HALF_DIV32 6'h0f
`define HALF_DIV64 6'h1f
`define HALF_DIV128 6'h3f

// synchroniser lanes
`define SYNC_W 4
`define LANE_SS 0
`define LANE_MISO 1
`define LANE_START 2
`define LANE_DONE 3
// toggle lanes idle low like the link toggles, select and miso lanes high
`define SYNC_RST 4'h3

`endif

// file: spi_port_pkg.sv
// types shared by the serial port core, its monitor and its bench
// assumes spi_port_params.svh is on the include path
package spi_port_pkg;

  // software-written control register
  typedef struct packed {
    logic irq_enable_bit;
    logic port_enable_bit;
    logic master_select_bit;
    logic idle_level_bit;
    logic capture_phase_bit;
    logic [2:0] rate_select_field;
  } cfg_t;

  // software-written bits of the control-status register
  typedef struct packed {
    logic output_disable_bit;
    logic select_source_bit;
    logic soft_select_bit;
  } csr_ctl_t;

  // hardware-set flags of the control-status register
  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic master_fault_flag;
  } status_t;

  typedef enum logic {M_IDLE, M_RUN} m_state_t;

endpackage

// file: slave_link.sv
// slave-mode shifter clocked by the external serial clock
// assumes idle level and phase are held still while link_rstn is high
`timescale 1ns/1ps
`include "spi_port_params.svh"

module slave_link (
  // clocks and resets
  input wire logic sck,
  input wire logic rstn,
  input wire logic link_rstn,
  // mode
  input wire logic idle_level_bit,
  input wire logic capture_phase_bit,
  // serial data
  input wire logic mosi,
  output logic miso,
  // toward the cpu domain
  input wire logic [`BYTE_W-1:0] tx_byte,
  output logic [`BYTE_W-1:0] rx_byte,
  output logic start_tgl,
  output logic done_tgl
);

  // capture edge becomes the rising edge of sck_eff in all four modes
  logic sck_eff;
  assign sck_eff = sck ^ (idle_level_bit ^ capture_phase_bit);

  logic [`BIT_CNT_W-1:0] cnt, next_cnt;
  logic [`BYTE_W-1:0] rx_sh, next_rx_sh, next_rx_byte;
  logic next_start_tgl, next_done_tgl;
  logic started, out_bit, next_out_bit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_rx_sh = {rx_sh[`BYTE_W-2:0], mosi};
    next_cnt = cnt + 3'h1;
    next_start_tgl = start_tgl;
    next_done_tgl = done_tgl;
    next_rx_byte = rx_byte;
    if (cnt == 3'h0) begin
      next_start_tgl = ~start_tgl;
    end
    if (cnt == `LAST_BIT) begin
      next_rx_byte = next_rx_sh;
      next_done_tgl = ~done_tgl;
    end
    next_out_bit = tx_byte[`LAST_BIT - cnt];
  end

  // bit position restarts with every deselect
  always_ff @(posedge sck_eff or negedge link_rstn) begin
    if (!link_rstn) begin
      cnt <= 3'h0;
      rx_sh <= 8'h00;
    end else begin
      cnt <= next_cnt;
      rx_sh <= next_rx_sh;
    end
  end

  // toggles survive deselect so the cpu side never sees a false event
  always_ff @(posedge sck_eff or negedge rstn) begin
    if (!rstn) begin
      rx_byte <= 8'h00;
      start_tgl <= 1'b0;
      done_tgl <= 1'b0;
    end else begin
      rx_byte <= next_rx_byte;
      start_tgl <= next_start_tgl;
      done_tgl <= next_done_tgl;
    end
  end

  always_ff @(negedge sck_eff or negedge link_rstn) begin
    if (!link_rstn) begin
      started <= 1'b0;
      out_bit <= 1'b0;
    end else begin
      started <= 1'b1;
      out_bit <= next_out_bit;
    end
  end

  // msb stands on the line before the first edge
  assign miso = started ? out_bit : tx_byte[`BYTE_W-1];

endmodule

// file: spi_port_monitor.sv
// concurrent checks on the serial port core outputs
// assumes it is bound into spi_port and watches the clk domain only
`timescale 1ns/1ps

module spi_port_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // accesses
  input wire logic csr_rd,
  input wire logic dr_wr,
  input wire logic [7:0] dr_wdata,
  input wire logic dr_rd,
  input wire logic cpu_irq_mask,
  input wire logic halt,
  // watched outputs
  input wire spi_port_pkg::cfg_t cfg,
  input wire spi_port_pkg::status_t status,
  input wire logic irq,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic mosi_o,
  input wire logic mosi_oe
);
  import spi_port_pkg::*;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////
  sequence s_fault_held;
    status.master_fault_flag [*2];
  endsequence

  property p_fault_drop;
    $rose(status.master_fault_flag) |->
      !cfg.port_enable_bit && !cfg.master_select_bit;
  endproperty
  a_fault_drop: assert property (p_fault_drop)
    else $error("enable kept on fault");

  property p_fault_quiet;
    s_fault_held |-> !sck_oe && !mosi_oe;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet)
    else $error("outputs driven in fault");

  property p_fault_lock;
    s_fault_held |-> !cfg.port_enable_bit && !cfg.master_select_bit;
  endproperty
  a_fault_lock: assert property (p_fault_lock)
    else $error("enable set during fault");

  // write_collision_flag is left out on purpose: it never requests service
  property p_irq;
    irq == ($past(cfg.irq_enable_bit) && !$past(cpu_irq_mask) &&
      ($past(status.transfer_done_flag) || $past(status.overrun_flag) ||
      $past(status.master_fault_flag)));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq mismatch");

  property p_done_clear;
    $fell(status.transfer_done_flag) |-> $past(dr_rd) || $past(dr_wr);
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done flag cleared early");

  property p_ovr_clear;
    csr_rd && !halt |=> !status.overrun_flag;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear)
    else $error("overrun kept after read");

  property p_mosi_load;
    dr_wr && !halt && cfg.port_enable_bit && cfg.master_select_bit &&
      !status.transfer_done_flag && !status.write_collision_flag |=>
      mosi_o == $past(dr_wdata[7]) || status.write_collision_flag;
  endproperty
  a_mosi_load: assert property (p_mosi_load)
    else $error("msb not on mosi");

  property p_idle;
    status.transfer_done_flag && cfg.master_select_bit && $stable(cfg)
      |-> sck_o == cfg.idle_level_bit;
  endproperty
  a_idle: assert property (p_idle)
    else $error("sck not idle");

  c_done: cover property ($rose(status.transfer_done_flag));
  c_ovr: cover property ($rose(status.overrun_flag));
  c_fault: cover property ($rose(status.master_fault_flag));
endmodule

bind spi_port spi_port_monitor mon_u (.clk(clk), .rstn(rstn),
  .csr_rd(csr_rd), .dr_wr(dr_wr), .dr_wdata(dr_wdata), .dr_rd(dr_rd),
  .cpu_irq_mask(cpu_irq_mask), .halt(halt), .cfg(cfg), .status(status),
  .irq(irq), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o),
  .mosi_oe(mosi_oe));

// file: remote_slave.sv
// far-side serial slave facing the port in master mode
// assumes the bench pulses load after sck has settled at its idle level
`timescale 1ns/1ps

module remote_slave (
  // serial pins
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // set-up
  input wire logic idle_level_bit,
  input wire logic capture_phase_bit,
  input wire logic sel,
  input wire logic load,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  logic bit_q;
  wire cap = sck ^ idle_level_bit ^ capture_phase_bit;

  // phase zero needs the msb on the line before the first edge
  always @(posedge load) begin
    bit_q = tx_byte[7];
    sh = capture_phase_bit ? tx_byte : tx_byte << 1;
  end
  always @(posedge cap) if (sel) rx_byte <= {rx_byte[6:0], mosi};
  always @(negedge cap) if (sel) begin
    bit_q <= sh[7];
    sh <= sh << 1;
  end
  // a released line must not echo the last bit
  assign miso = sel ? bit_q : ~bit_q;
endmodule

// file: tb_spi_port.sv
// self-checking bench for the serial port core
// assumes spi_port_params.svh on the include path and a far slave model
`timescale 1ns/1ps
`include "spi_port_params.svh"

module tb_spi_port;
  import spi_port_pkg::*;
  localparam int CR = 0;
  localparam int RD = 1;
  localparam int CS = 2;
  localparam int DW = 3;
  localparam int DR = 4;
  logic clk, rstn, sck_link, cr_wr, csr_rd, csr_wr, dr_wr, dr_rd;
  logic cpu_irq_mask, halt, ss_pin_n, mosi_in, pol, pha, s_en, s_load;
  logic irq, wake, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, s_miso;
  logic [7:0] dr_wdata, dr_rdata, s_tx, s_rx;
  cfg_t cr_wdata, cfg;
  csr_ctl_t csr_wdata, csr_ctl;
  status_t status;
  logic woke = 1'b0;
  int fail_count = 0;
  int checked = 0;

  spi_port dut_u (.clk(clk), .rstn(rstn), .sck_link(sck_link),
    .cr_wr(cr_wr), .cr_wdata(cr_wdata), .csr_rd(csr_rd), .csr_wr(csr_wr),
    .csr_wdata(csr_wdata), .dr_wr(dr_wr), .dr_wdata(dr_wdata),
    .dr_rd(dr_rd), .cpu_irq_mask(cpu_irq_mask), .halt(halt), .cfg(cfg),
    .csr_ctl(csr_ctl), .status(status), .dr_rdata(dr_rdata), .irq(irq),
    .wake(wake), .ss_pin_n(ss_pin_n), .mosi_in(mosi_in), .miso_in(s_miso),
    .sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_o(miso_o), .miso_oe(miso_oe));
  remote_slave far_u (.sck(sck_o), .mosi(mosi_o), .miso(s_miso),
    .idle_level_bit(pol), .capture_phase_bit(pha), .sel(s_en),
    .load(s_load), .tx_byte(s_tx), .rx_byte(s_rx));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // wake is a one-cycle pulse; keep it until the scenario looks
  always @(posedge clk) if (wake === 1'b1) woke <= 1'b1;

  ////////////////////////////////////////
  task automatic acc(input int k, input logic [7:0] d);
    @(posedge clk) begin
      case (k)
        CR: begin
          cr_wr <= 1'b1;
          cr_wdata <= cfg_t'(d);
        end
        RD: csr_rd <= 1'b1;
        CS: begin
          csr_wr <= 1'b1;
          csr_wdata <= csr_ctl_t'(d[2:0]);
        end
        DW: begin
          dr_wr <= 1'b1;
          dr_wdata <= d;
        end
        default: dr_rd <= 1'b1;
      endcase
    end
    @(posedge clk) {cr_wr, csr_rd, csr_wr, dr_wr, dr_rd} <= 5'h00;
    #1;
  endtask

  task automatic chk(input logic [7:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_st(input logic [3:0] exp);
    chk({4'h0, status}, {4'h0, exp}, "status");
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (status.transfer_done_flag !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // the bench plays the far master; sck runs only inside the frame
  task automatic frame(input logic [7:0] d, output logic [7:0] q);
    @(posedge clk) ss_pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    #7;
    chk(miso_oe, 1'b1, "miso_oe");
    for (int i = 7; i >= 0; i--) begin
      mosi_in = d[i];
      #40 q[i] = miso_o;
      sck_link = 1'b1;
      #40 sck_link = 1'b0;
    end
    mosi_in = ~d[0];
    repeat (8) @(posedge clk);
    ss_pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////
  task automatic t_master;
    for (int m = 0; m < 4; m++) begin
      pol = m[1];
      pha = m[0];
      acc(CR, {3'b100, pol, pha, `RATE_DIV128});
      acc(CS, 8'h03);
      acc(CR, {3'b111, pol, pha, `RATE_DIV128});
      repeat (2) @(posedge clk);
      s_tx = 8'h3c + m[7:0];
      s_load = 1'b1;
      #1 s_load = 1'b0;
      chk(sck_o, pol, "idle");
      chk({sck_oe, mosi_oe}, 2'b11, "oe");
      chk(csr_ctl, 3'h3, "csr");
      acc(DW, 8'ha0 + m[7:0]);
      wait_done;
      @(posedge clk);
      #1;
      chk_st(4'h8);
      chk(irq, 1'b1, "irq");
      chk(s_rx, 8'ha0 + m[7:0], "mosi");
      chk(dr_rdata, 8'h3c + m[7:0], "rx");
      acc(RD, 8'h00);
      acc(DR, 8'h00);
      chk_st(4'h0);
    end
    $display("master modes finished");
  endtask

  task automatic t_flags;
    pol = 1'b0;
    pha = 1'b0;
    acc(CR, {3'b100, 2'b00, `RATE_DIV4});
    acc(CR, {3'b111, 2'b00, `RATE_DIV4});
    acc(DW, 8'h81);
    acc(DW, 8'h7e);
    chk_st(4'h4);
    wait_done;
    chk(s_rx, 8'h81, "kept");
    acc(DW, 8'h55);
    repeat (40) @(posedge clk);
    chk(s_rx, 8'h81, "inhibit");
    acc(RD, 8'h00);
    acc(DR, 8'h00);
    chk_st(4'h0);
    $display("flag checks finished");
  endtask

  task automatic t_slave;
    logic [7:0] q;
    acc(CR, 8'h00);
    acc(CS, 8'h00);
    acc(CR, 8'h40);
    acc(DW, 8'hc3);
    frame(8'h96, q);
    chk(q, 8'hc3, "miso");
    chk(dr_rdata, 8'h96, "rx");
    chk_st(4'h8);
    frame(8'h69, q);
    chk_st(4'ha);
    chk(dr_rdata, 8'h96, "first");
    acc(RD, 8'h00);
    chk_st(4'h8);
    acc(DR, 8'h00);
    chk_st(4'h0);
    // halt entered while selected: strobes frozen, a byte still wakes
    @(posedge clk) ss_pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    halt <= 1'b1;
    acc(CR, 8'h00);
    frame(8'h5a, q);
    chk(cfg, 8'h40, "frozen");
    chk(dr_rdata, 8'h5a, "halt rx");
    chk(woke, 1'b1, "wake");
    @(posedge clk) halt <= 1'b0;
    acc(RD, 8'h00);
    acc(DR, 8'h00);
    chk_st(4'h0);
    $display("slave checks finished");
  endtask

  task automatic t_fault;
    s_en = 1'b0;
    acc(CR, {3'b111, 2'b00, `RATE_DIV4});
    @(posedge clk) ss_pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk_st(4'h1);
    chk(cfg[6:5], 2'b00, "drop");
    chk(irq, 1'b1, "irq");
    @(posedge clk) cpu_irq_mask <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1'b0, "mask");
    @(posedge clk) ss_pin_n <= 1'b1;
    acc(CR, {3'b111, 2'b00, `RATE_DIV4});
    chk(cfg[6:5], 2'b00, "lock");
    cpu_irq_mask <= 1'b0;
    repeat (4) @(posedge clk);
    acc(RD, 8'h00);
    acc(CR, {3'b111, 2'b00, `RATE_DIV4});
    chk_st(4'h0);
    chk(cfg[6:5], 2'b11, "restore");
    $display("fault checks finished");
  endtask

  task automatic print_verdict;
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {rstn, sck_link, cr_wr, csr_rd, csr_wr, dr_wr, dr_rd, halt} = 8'h00;
    {cpu_irq_mask, mosi_in, pol, pha, s_load, ss_pin_n, s_en} = 7'h03;
    cr_wdata = cfg_t'(8'h00);
    csr_wdata = csr_ctl_t'(3'h0);
    dr_wdata = 8'h00;
    s_tx = 8'h00;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // let the pin synchronisers settle before any access
    repeat (4) @(posedge clk);
    t_master;
    t_flags;
    t_slave;
    t_fault;
    print_verdict;
  end

  initial begin
    #1000000;
    fail_count++;
    print_verdict;
  end
endmodule
